// ==== hw/sbm_pkg.sv ====
// Shared constants and carrier types of the serial bit memory block
package sbm_pkg;
  // Word counter and serial address geometry
  localparam int unsigned SBM_ADDR_W  = 22;
  localparam int unsigned SBM_SADDR_W = 13;
  localparam int unsigned SBM_BLOCK_W = 10;
  localparam int unsigned SBM_PAGE_W  = SBM_ADDR_W - SBM_BLOCK_W;
  // Reset values, block offset, count step and write buffer depth
  localparam logic [SBM_ADDR_W-1:0]  SBM_CNT_RST  = 22'h0;
  localparam logic [SBM_SADDR_W-1:0] SBM_SREG_RST = 13'h0;
  localparam logic [SBM_BLOCK_W-1:0] SBM_BLOCK_LO = 10'h0;
  localparam logic [SBM_ADDR_W-1:0]  SBM_CNT_ONE  = 22'h1;
  localparam int unsigned SBM_WBUF_DEPTH = 2;

  // Access cycle modes
  typedef enum logic [1:0] {
    SBM_IDLE,
    SBM_READ,
    SBM_EARLY_WR,
    SBM_RMW
  } sbm_mode_t;

  // One pending bit write
  typedef struct packed {
    logic [SBM_ADDR_W-1:0] addr;
    logic                  data;
  } sbm_wr_t;
endpackage

// ==== hw/sbm_fifo.sv ====
// Small valid/ready FIFO used as the write buffer
`timescale 1ns/1ps
`default_nettype none
module sbm_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  // Honest full and empty flags
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Entry storage, no reset needed for data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + (PW+1)'(1);
    end else if (pop && !push) begin
      count <= count - (PW+1)'(1);
    end
  end
endmodule // sbm_fifo
`default_nettype wire

// ==== hw/sbm_core.sv ====
// Pin-level access logic and bit array of the serial bit memory
//
// Function
// - Start address arrives serially as 13 bits, granularity 1024 words.
// - Each address strobe pulse captures the address data pin.
// - Load strobe copies the serial address register into the counter.
// - Read mode: clock falling edge presents addressed bit on output.
// - Write mode: clock falling edge takes data input for current address.
// - Every clock rising edge without a load in the same cycle advances the word counter by one.
// - Write enable high selects read, low selects write.
// - Write enable falling while clock low in a read cycle makes read-modify-write.
// - Read-modify-write samples data input on write enable falling edge.
// - Output is high impedance while clock or chip select is high.
// - Read value is held on output until the clock rises.
// - Early write keeps output in high impedance.
// - Chip select high makes the device ignore all other inputs.
`timescale 1ns/1ps
`default_nettype none
module sbm_core #(
  parameter int unsigned ADDR_W = sbm_pkg::SBM_ADDR_W
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic ser_addr_in,
  input  wire logic addr_shift_strobe,
  input  wire logic addr_load_strobe,
  input  wire logic access_clock_n,
  input  wire logic we_n,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout,
  output logic      dout_oe
);
  localparam int unsigned SW = sbm_pkg::SBM_SADDR_W;
  localparam int unsigned AW = sbm_pkg::SBM_ADDR_W;

  logic [0:0]          bits [2**ADDR_W];
  logic [SW-1:0]       sreg;
  logic [AW-1:0]       addr_cnt;
  logic [AW-1:0]       load_val;
  logic [AW-1:0]       next_addr_inc;
  sbm_pkg::sbm_mode_t  mode;
  logic                prev_sas;
  logic                prev_tas;
  logic                prev_clk_n;
  logic                prev_we_n;
  logic                sel;
  logic                sas_rise;
  logic                tas_rise;
  logic                clk_fall;
  logic                clk_rise;
  logic                we_fall;
  logic                rd_start;
  logic                rd_bit;
  logic                rd_drive;
  logic                push_valid;
  logic                push_ready;
  sbm_pkg::sbm_wr_t    push_data;
  logic                pop_valid;
  logic                pop_ready;
  sbm_pkg::sbm_wr_t    pop_data;

  // Previous pin levels; clocks idle high so power-up gives no edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prev_sas   <= 1'b1;
      prev_tas   <= 1'b1;
      prev_clk_n <= 1'b1;
      prev_we_n  <= 1'b1;
    end else begin
      prev_sas   <= addr_shift_strobe;
      prev_tas   <= addr_load_strobe;
      prev_clk_n <= access_clock_n;
      prev_we_n  <= we_n;
    end
  end

  assign sel      = ~cs_n;
  assign sas_rise = sel & addr_shift_strobe & ~prev_sas;
  assign tas_rise = sel & addr_load_strobe & ~prev_tas;
  assign clk_fall = sel & ~access_clock_n & prev_clk_n;
  assign clk_rise = sel & access_clock_n & ~prev_clk_n;
  // write enable falling inside an active read
  assign we_fall  = sel & ~we_n & prev_we_n & ~access_clock_n
                    & (mode == sbm_pkg::SBM_READ);
  // mode chosen by write enable at clock fall
  assign rd_start = clk_fall & we_n;
  assign rd_bit   = bits[addr_cnt[ADDR_W-1:0]][0];

  // shift in one address bit per strobe
  // newest bit enters at the top, so A0 ends in bit 0
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sreg <= sbm_pkg::SBM_SREG_RST;
    end else if (sas_rise) begin
      sreg <= {ser_addr_in, sreg[SW-1:1]};
    end
  end

  // dummy top bit is dropped; low bits give a 1024-word block
  assign load_val      = {sreg[sbm_pkg::SBM_PAGE_W-1:0],
                          sbm_pkg::SBM_BLOCK_LO};
  assign next_addr_inc = addr_cnt + sbm_pkg::SBM_CNT_ONE;

  // load on transfer strobe; a load wins over an increment
  // count up on clock rising edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_cnt <= sbm_pkg::SBM_CNT_RST;
    end else if (tas_rise) begin
      addr_cnt <= load_val;
    end else if (clk_rise) begin
      addr_cnt <= next_addr_inc;
    end
  end

  // Access cycle mode; a new fall always restarts it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode <= sbm_pkg::SBM_IDLE;
    end else if (clk_fall) begin
      mode <= we_n ? sbm_pkg::SBM_READ : sbm_pkg::SBM_EARLY_WR;
    end else if (clk_rise) begin
      mode <= sbm_pkg::SBM_IDLE;
    end else if (we_fall) begin
      mode <= sbm_pkg::SBM_RMW;
    end
  end

  // output latch takes the addressed bit at the fall
  // held until the next read fall; the enable masks it after the rise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dout <= 1'b0;
    end else if (rd_start) begin
      dout <= rd_bit;
    end
  end

  // drive only while clock low and chip selected
  assign rd_drive = (mode == sbm_pkg::SBM_READ) | (mode == sbm_pkg::SBM_RMW);
  assign dout_oe  = rd_drive & ~access_clock_n & ~cs_n;

  // early write takes din at the clock fall
  // read-modify-write takes din at the write enable fall
  assign push_valid     = (clk_fall & ~we_n) | we_fall;
  assign push_data.addr = addr_cnt;
  assign push_data.data = din;

  // Array is single ported: a read stalls the drain for one cycle,
  // which is why two entries are enough for back-to-back writes
  assign pop_ready = ~rd_start;

  sbm_fifo #(
    .W     ($bits(sbm_pkg::sbm_wr_t)),
    .DEPTH (sbm_pkg::SBM_WBUF_DEPTH)
  ) u_wbuf (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // Commit buffered writes to the bit array
  always_ff @(posedge sys_clk) begin
    if (pop_valid && pop_ready) begin
      bits[pop_data.addr[ADDR_W-1:0]] <= pop_data.data;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_read_begin;
    rd_start;
  endsequence

  sequence s_rmw_turn;
    (mode == sbm_pkg::SBM_READ) && we_fall;
  endsequence

  a_shift_capture: assert property (
    sas_rise |=> sreg[SW-1] == $past(ser_addr_in))
    else $error("address bit not captured");

  a_counter_load: assert property (
    tas_rise |=> addr_cnt == $past(load_val))
    else $error("counter not loaded from serial register");

  a_block_align: assert property (
    tas_rise |=> addr_cnt[sbm_pkg::SBM_BLOCK_W-1:0] == '0)
    else $error("loaded address not block aligned");

  a_count_step: assert property (
    clk_rise && !tas_rise |=> addr_cnt == $past(next_addr_inc))
    else $error("counter did not advance by one");

  a_read_present: assert property (
    s_read_begin ##1 !access_clock_n && !cs_n |-> dout_oe)
    else $error("read bit not driven");

  // Array is never cleared, so dummy reads may present unknown bits
  a_read_value: assert property (
    rd_start |=> dout === $past(rd_bit))
    else $error("wrong bit presented");

  a_mode_select: assert property (
    clk_fall |=> (mode == sbm_pkg::SBM_READ) == $past(we_n))
    else $error("mode does not follow write enable");

  a_hiz_idle: assert property (
    access_clock_n || cs_n |-> !dout_oe)
    else $error("output driven while clock or select high");

  a_read_hold: assert property (
    dout_oe && $past(dout_oe) |-> dout === $past(dout))
    else $error("read value changed while driven");

  a_early_hiz: assert property (
    clk_fall && !we_n |=> !dout_oe)
    else $error("early write drove the output");

  a_write_take: assert property (
    clk_fall && !we_n |-> push_valid && push_data.data == din)
    else $error("write data not taken at clock fall");

  a_rmw_sample: assert property (
    s_rmw_turn |-> push_valid && push_data.data == din
      ##1 mode == sbm_pkg::SBM_RMW && $stable(dout))
    else $error("read-modify-write not entered correctly");

  a_select_ignore: assert property (
    cs_n |-> !dout_oe ##1 $stable(sreg) && $stable(addr_cnt))
    else $error("inputs acted on while deselected");

  a_select_mode: assert property (
    cs_n |=> $stable(mode))
    else $error("access mode changed while deselected");

  // Serial register shifts by exactly one place per strobe
  a_shift_order: assert property (
    sas_rise |=> sreg[SW-2:0] == $past(sreg[SW-1:1]))
    else $error("serial register did not shift down");

  a_addr_quiet: assert property (
    !sas_rise |=> $stable(sreg))
    else $error("serial register moved without a strobe");

  a_count_hold: assert property (
    !clk_rise && !tas_rise |=> $stable(addr_cnt))
    else $error("counter moved without a rise or load");

  // Output register only moves when a read starts
  a_dout_quiet: assert property (
    !rd_start |=> dout === $past(dout))
    else $error("output bit changed outside a read start");

  a_rmw_hold: assert property (
    mode == sbm_pkg::SBM_RMW && !access_clock_n && !cs_n |-> dout_oe)
    else $error("read value dropped during the write half");

  // Only a running read can turn into read-modify-write
  sequence s_rmw_enter;
    $changed(mode) && mode == sbm_pkg::SBM_RMW;
  endsequence

  a_rmw_origin: assert property (
    s_rmw_enter |-> $past(mode) == sbm_pkg::SBM_READ)
    else $error("read-modify-write entered from a non-read cycle");

  a_early_stays: assert property (
    mode == sbm_pkg::SBM_EARLY_WR && !clk_rise && !clk_fall
      |=> mode == sbm_pkg::SBM_EARLY_WR)
    else $error("early write cycle changed mode");

  // One push per access phase never meets a full buffer, and a
  // read start delays the drain by one cycle at most
  sequence s_commit;
    pop_valid && pop_ready;
  endsequence

  a_wbuf_room: assert property (
    push_valid |-> push_ready)
    else $error("write buffer full, bit would be lost");

  a_wbuf_drain: assert property (
    pop_valid |-> ##[0:1] pop_ready)
    else $error("write buffer not drained");

  a_write_land: assert property (
    s_commit |=> bits[$past(pop_data.addr[ADDR_W-1:0])]
      == $past(pop_data.data))
    else $error("buffered bit not stored in the array");
endmodule // sbm_core
`default_nettype wire

// ==== dv/sbm_ctrl_model.sv ====
// Controller model that drives the access pins of the bit memory
`timescale 1ns/1ps
`default_nettype none
module sbm_ctrl_model (
  input  wire logic sys_clk,
  output logic      ser_addr_in,
  output logic      addr_shift_strobe,
  output logic      addr_load_strobe,
  output logic      access_clock_n,
  output logic      we_n,
  output logic      cs_n,
  output logic      din
);
  initial begin
    ser_addr_in = 1'b0;
    addr_shift_strobe = 1'b1;
    addr_load_strobe = 1'b1;
    access_clock_n = 1'b1;
    we_n = 1'b1;
    cs_n = 1'b0;
    din = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic select(input logic s);
    cs_n = ~s;
    hold(2);
  endtask
  // A0 first, dummy bit at a real level
  task automatic shift_addr(input logic [12:0] a);
    for (int i = 0; i < 13; i++) begin
      ser_addr_in = a[i];
      addr_shift_strobe = 1'b0;
      hold(2);
      addr_shift_strobe = 1'b1;
      hold(2);
    end
    ser_addr_in = ~a[12]; // Hold over: no stale level
  endtask
  // load after all bits, before the clock
  task automatic load();
    addr_load_strobe = 1'b0;
    hold(2);
    addr_load_strobe = 1'b1;
    hold(2);
  endtask
  // One clock low phase; rmw drops write enable mid-phase
  task automatic access(input logic wr, input logic d, input logic rmw,
                        input logic d2);
    we_n = ~wr;
    din = d;
    hold(1);
    access_clock_n = 1'b0;
    hold(3);
    if (rmw) begin
      we_n = 1'b0;
      din = d2;
      hold(3);
    end
    access_clock_n = 1'b1;
    we_n = 1'b1;
    din = ~din;
    hold(3);
  endtask
  // settle pause, then ten dummy reads
  task automatic power_up();
    hold(25000);
    repeat (10) access(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
endmodule // sbm_ctrl_model
`default_nettype wire

// ==== dv/serial_bit_memory_access_tb_top.sv ====
// Self-checking bench of the serial bit memory core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %b want %b", $time, a, b); end end
module serial_bit_memory_access_tb_top;
  localparam int unsigned AW = 12;
  logic sys_clk, srst, ser_addr_in, addr_shift_strobe, addr_load_strobe;
  logic access_clock_n, we_n, cs_n, din, dout, dout_oe;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rng = 32'h37923a70;
  logic [1:0] exp_q[$]; // Check flag, expected bit
  logic [1:0] e;
  logic mem [int];
  logic [AW-1:0] ptr;
  logic [21:0] blk;
  logic [12:0] a;
  logic oe_q = 1'b0;
  logic dout_q = 1'b0;
  logic skip = 1'b1;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  sbm_core #(.ADDR_W(AW)) i_dut (.sys_clk(sys_clk), .srst(srst),
    .ser_addr_in(ser_addr_in), .addr_shift_strobe(addr_shift_strobe),
    .addr_load_strobe(addr_load_strobe), .access_clock_n(access_clock_n),
    .we_n(we_n), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));
  sbm_ctrl_model i_ctrl (.sys_clk(sys_clk), .ser_addr_in(ser_addr_in),
    .addr_shift_strobe(addr_shift_strobe),
    .addr_load_strobe(addr_load_strobe), .access_clock_n(access_clock_n),
    .we_n(we_n), .cs_n(cs_n), .din(din));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // block start is the low twelve bits times 1024
  task automatic set_addr(input logic [12:0] x);
    i_ctrl.shift_addr(x);
    i_ctrl.load();
    blk = {x[11:0], 10'h0};
    ptr = blk[AW-1:0];
  endtask
  task automatic wr(input logic d);
    i_ctrl.access(1'b1, d, 1'b0, 1'b0);
    mem[ptr] = d;
    ptr++;
  endtask
  // read with random din that must be ignored
  task automatic rd();
    rng = xs(rng);
    exp_q.push_back({1'b1, mem[ptr]});
    i_ctrl.access(1'b0, rng[3], 1'b0, 1'b0);
    ptr++;
  endtask
  // read old bit, then store din at write enable fall
  task automatic rmw(input logic d);
    exp_q.push_back({1'b1, mem[ptr]});
    i_ctrl.access(1'b0, ~d, 1'b1, d);
    mem[ptr] = d;
    ptr++;
  endtask
  task automatic final_report();
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Output watcher, just after inputs change
  always begin
    @(negedge sys_clk);
    #1;
    // no drive while clock or select high
    if (cs_n || access_clock_n) `CHK(dout_oe, 1'b0)
    if (dout_oe === 1'b1 && oe_q === 1'b1) `CHK(dout, dout_q)
    if (dout_oe === 1'b1 && oe_q === 1'b0 && !skip) begin
      // early write must leave the pin undriven
      if (exp_q.size() == 0) `CHK(dout_oe, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK(dout, e[0])
      end
    end
    oe_q = dout_oe;
    dout_q = dout;
  end
  // Hang guard, well above the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    srst = 1'b1;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    i_ctrl.power_up();
    skip = 1'b0;
    // reload with flipped dummy bit reaches the same block
    repeat (3) begin
      rng = xs(rng);
      a = rng[12:0];
      set_addr(a);
      for (int i = 0; i < 8; i++) wr(rng[i+16]);
      set_addr(a ^ 13'h1000);
      repeat (8) rd();
    end
    set_addr(a);
    for (int i = 0; i < 4; i++) rmw(~mem[ptr]);
    set_addr(a);
    repeat (4) rd();
    // deselected strobes, loads and writes have no effect
    set_addr(a);
    rd();
    i_ctrl.select(1'b0);
    i_ctrl.shift_addr(~a);
    i_ctrl.load();
    i_ctrl.access(1'b1, ~mem[ptr], 1'b0, 1'b0);
    i_ctrl.access(1'b0, 1'b0, 1'b0, 1'b0);
    i_ctrl.select(1'b1);
    repeat (3) rd();
    i_ctrl.hold(10);
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule // serial_bit_memory_access_tb_top
`default_nettype wire
